/* File: hw/blfs_map.vh */
/*
 constants for the backlight fault and status block with its two-wire slave port.
 assumes a 200 MHz core clock and comparator levels already synchronous-free from the analog side.
*/
// Operation
// - low headroom then overvoltage sets bits 0, 4
// - open string turns boost off
// - sink above short level stops all, standby
// - overcurrent kills switch for rest of period
// - 32 windows with overcurrent set bit 1
// - overtemperature stops device, sets bit 2
// - restart once temperature falls to restart level
// - grounded or floating sink channel is excluded; the code still lets its short level freeze standby
// - bus busy from start until stop
// - answer only own seven-bit address
// - address bit eight selects direction
// - direction fixed until repeated start
// - write: register index byte, then data
// - bytes eight bits, msb first, unlimited count
// - receiver acknowledges after each byte
// - slave may stretch clock low
// - seven eight-bit registers on the bus
// - overvoltage flagged only after 1 ms qualification
`ifndef BLFS_MAP_VH
`define BLFS_MAP_VH
`define BLFS_SLAVE_ADDR   7'h36
`define BLFS_NUM_REGS     4'h7
`define BLFS_REG_FAULT    3'h6
`define BLFS_REG_CTRL     3'h0
`define BLFS_REG_MODE     3'h1
`define BLFS_FLT_OV       0
`define BLFS_FLT_OC       1
`define BLFS_FLT_OT       2
`define BLFS_FLT_OPEN     4
`define BLFS_CLK_MHZ      200
`define BLFS_OV_QUAL_US   1000
`define BLFS_OV_QUAL_CYC  (`BLFS_OV_QUAL_US * `BLFS_CLK_MHZ)
`define BLFS_OC_WIN_US    128
`define BLFS_OC_WIN_CYC   (`BLFS_OC_WIN_US * `BLFS_CLK_MHZ)
`define BLFS_OC_WINDOWS   6'h20
`endif

/* File: hw/blfs_top.v */
/*
 backlight fault logic plus two-wire slave with a seven-register file.
 assumes comparator inputs are asynchronous and the bus pins are open drain, resolved outside.
*/
`timescale 1ns/1ps
`include "blfs_map.vh"
module blfs_top #(
	parameter OV_QUAL_CYC = `BLFS_OV_QUAL_CYC, // shortenable in simulation
	parameter OC_WIN_CYC  = `BLFS_OC_WIN_CYC
) (
	input  wire       clk,
	input  wire       reset,
	input  wire       scl_in,
	output reg        scl_oe_ff,
	output wire       scl_out,
	input  wire       sda_in,
	output reg        sda_oe_ff,
	output wire       sda_out,
	input  wire       stretch_req,
	input  wire [2:0] sink_headroom_low,
	input  wire       over_voltage_guard,
	input  wire [2:0] sink_short_high,
	input  wire       switch_overcurrent_guard,
	input  wire       switch_period_start,
	input  wire       temp_above_upper,
	input  wire       temp_below_restart,
	input  wire [2:0] string_sink_pin_unused,
	input  wire       hardware_enable_pin,
	output reg        boost_enable_ff,
	output reg        switch_gate_ff,
	output reg  [2:0] sink_enable_ff,
	output reg        standby_ff,
	output reg  [7:0] fault_flags_ff,
	output reg        bus_busy_ff
);
	// open drain: always drive low when enabled
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// three-stage samplers; second and third must agree
	reg [2:0] scl_s_ff, sda_s_ff;
	reg       scl_ff, sda_ff, scl_prev_ff, sda_prev_ff;
	reg [2:0] hr_s1_ff, hr_s2_ff, hr_s3_ff;
	reg [2:0] sh_s1_ff, sh_s2_ff, sh_s3_ff;
	reg [2:0] un_s1_ff, un_s2_ff, un_s3_ff;
	reg [4:0] m_s1_ff, m_s2_ff, m_s3_ff;  // ov, oc, tup, tlow, en
	reg [2:0] hr_ff, sh_ff, un_ff;
	reg [4:0] m_ff;
	always @(posedge clk) begin
		if (reset) begin
			scl_s_ff <= 3'h7; sda_s_ff <= 3'h7;
			scl_ff <= 1'b1; sda_ff <= 1'b1; scl_prev_ff <= 1'b1; sda_prev_ff <= 1'b1;
			hr_s1_ff <= 3'h0; hr_s2_ff <= 3'h0; hr_s3_ff <= 3'h0; hr_ff <= 3'h0;
			sh_s1_ff <= 3'h0; sh_s2_ff <= 3'h0; sh_s3_ff <= 3'h0; sh_ff <= 3'h0;
			un_s1_ff <= 3'h0; un_s2_ff <= 3'h0; un_s3_ff <= 3'h0; un_ff <= 3'h0;
			m_s1_ff <= 5'h00; m_s2_ff <= 5'h00; m_s3_ff <= 5'h00; m_ff <= 5'h00;
		end else begin
			scl_s_ff <= {scl_s_ff[1:0], scl_in};
			sda_s_ff <= {sda_s_ff[1:0], sda_in};
			if (scl_s_ff[1] == scl_s_ff[2]) scl_ff <= scl_s_ff[2];
			if (sda_s_ff[1] == sda_s_ff[2]) sda_ff <= sda_s_ff[2];
			scl_prev_ff <= scl_ff;
			sda_prev_ff <= sda_ff;
			hr_s1_ff <= sink_headroom_low; hr_s2_ff <= hr_s1_ff; hr_s3_ff <= hr_s2_ff;
			sh_s1_ff <= sink_short_high; sh_s2_ff <= sh_s1_ff; sh_s3_ff <= sh_s2_ff;
			un_s1_ff <= string_sink_pin_unused; un_s2_ff <= un_s1_ff; un_s3_ff <= un_s2_ff;
			m_s1_ff <= {hardware_enable_pin, temp_below_restart, temp_above_upper,
				switch_overcurrent_guard, over_voltage_guard};
			m_s2_ff <= m_s1_ff; m_s3_ff <= m_s2_ff;
			hr_ff <= (hr_s2_ff & hr_s3_ff) | (hr_ff & (hr_s2_ff | hr_s3_ff));
			sh_ff <= (sh_s2_ff & sh_s3_ff) | (sh_ff & (sh_s2_ff | sh_s3_ff));
			un_ff <= (un_s2_ff & un_s3_ff) | (un_ff & (un_s2_ff | un_s3_ff));
			m_ff  <= (m_s2_ff & m_s3_ff) | (m_ff & (m_s2_ff | m_s3_ff));
		end
	end
	wire ov_lvl = m_ff[0];
	wire oc_lvl = m_ff[1];
	wire t_up   = m_ff[2];
	wire t_low  = m_ff[3];
	wire hw_en  = m_ff[4];
	// period start comes from the core's own switching logic, same clock
	wire scl_rise = scl_ff & ~scl_prev_ff;
	wire scl_fall = ~scl_ff & scl_prev_ff;
	wire start_c  = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
	wire stop_c   = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;

	// register file: seven bytes, fault byte is hardware owned
	reg [7:0] regs_ff [0:6];
	reg [2:0] ptr_ff;

	// over-voltage qualification counter
	reg [31:0] ov_cnt_ff;
	reg        ov_q_ff;
	always @(posedge clk) begin
		if (reset) begin
			ov_cnt_ff <= 32'h0;
			ov_q_ff <= 1'b0;
		end else if (!ov_lvl) begin
			ov_cnt_ff <= 32'h0; // short excursions rejected
			ov_q_ff <= 1'b0;
		end else if (ov_cnt_ff < OV_QUAL_CYC) begin
			ov_cnt_ff <= ov_cnt_ff + 32'h1;
		end else begin
			ov_q_ff <= 1'b1;
		end
	end

	// over-current observation windows
	reg [31:0] win_cnt_ff;
	reg        win_hit_ff;
	reg [5:0]  win_run_ff;
	wire       win_end = (win_cnt_ff == OC_WIN_CYC - 1);
	always @(posedge clk) begin
		if (reset) begin
			win_cnt_ff <= 32'h0;
			win_hit_ff <= 1'b0;
			win_run_ff <= 6'h0;
		end else begin
			win_cnt_ff <= win_end ? 32'h0 : win_cnt_ff + 32'h1;
			if (win_end) begin
				win_hit_ff <= oc_lvl;
				// a quiet window breaks the run
				win_run_ff <= (win_hit_ff | oc_lvl) ?
					((win_run_ff == `BLFS_OC_WINDOWS) ? win_run_ff : win_run_ff + 6'h1) :
					6'h0;
			end else if (oc_lvl) begin
				win_hit_ff <= 1'b1;
			end
		end
	end

	// protection state and outputs
	reg ot_ff;
	wire [2:0] used = ~un_ff;
	always @(posedge clk) begin
		if (reset) begin
			fault_flags_ff <= 8'h00;
			ot_ff <= 1'b0;
			boost_enable_ff <= 1'b0;
			switch_gate_ff <= 1'b0;
			sink_enable_ff <= 3'h0;
			standby_ff <= 1'b1;
		end else begin
			if (ov_q_ff) fault_flags_ff[`BLFS_FLT_OV] <= 1'b1;
			if (ov_q_ff && |(hr_ff & used)) fault_flags_ff[`BLFS_FLT_OPEN] <= 1'b1;
			if (win_run_ff == `BLFS_OC_WINDOWS) fault_flags_ff[`BLFS_FLT_OC] <= 1'b1;
			if (t_up) begin
				ot_ff <= 1'b1;
				fault_flags_ff[`BLFS_FLT_OT] <= 1'b1;
			end else if (t_low) begin
				ot_ff <= 1'b0;
			end
			// short: standby until the short clears with ctrl bit 0 set and enable high
			if (|(sh_ff & used)) standby_ff <= 1'b1;
			else if (!hw_en) standby_ff <= 1'b1;
			else if (standby_ff && !regs_ff[`BLFS_REG_CTRL][0]) standby_ff <= 1'b1;
			else if (!(|sh_ff)) standby_ff <= ~regs_ff[`BLFS_REG_CTRL][0] | ~hw_en;
			boost_enable_ff <= !standby_ff && !ot_ff && !(|(sh_ff & used)) &&
				!fault_flags_ff[`BLFS_FLT_OPEN] && !ov_lvl;
			sink_enable_ff <= (standby_ff || ot_ff || |(sh_ff & used)) ? 3'h0 :
				(regs_ff[`BLFS_REG_CTRL][3:1] & used);
			// gate off for the rest of the period on overcurrent
			if (oc_lvl || standby_ff || ot_ff) switch_gate_ff <= 1'b0;
			else if (switch_period_start) switch_gate_ff <= boost_enable_ff;
		end
	end

	// two-wire slave
	localparam ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_AACK = 3'h2, ST_WR = 3'h3,
		ST_WACK = 3'h4, ST_RD = 3'h5, ST_RACK = 3'h6;
	reg [2:0] st_ff;
	reg [3:0] bit_ff;
	reg [7:0] sh_reg_ff;
	reg       have_ptr_ff;
	reg       nack_ff;
	integer   i;
	wire      strings_off = (regs_ff[`BLFS_REG_CTRL][3:1] == 3'h0);
	always @(posedge clk) begin
		if (reset) begin
			st_ff <= ST_IDLE; bit_ff <= 4'h0; sh_reg_ff <= 8'h00;
			have_ptr_ff <= 1'b0; ptr_ff <= 3'h0; nack_ff <= 1'b0;
			sda_oe_ff <= 1'b0; scl_oe_ff <= 1'b0; bus_busy_ff <= 1'b0;
			for (i = 0; i < 7; i = i + 1) regs_ff[i] <= 8'h00;
		end else begin
			regs_ff[`BLFS_REG_FAULT] <= fault_flags_ff;
			// stretch only while clock already low
			scl_oe_ff <= stretch_req && !scl_ff && st_ff != ST_IDLE;
			if (stop_c) begin
				bus_busy_ff <= 1'b0;
				st_ff <= ST_IDLE; sda_oe_ff <= 1'b0;
			end else if (start_c) begin
				bus_busy_ff <= 1'b1;
				st_ff <= ST_ADDR; bit_ff <= 4'h0; have_ptr_ff <= 1'b0; sda_oe_ff <= 1'b0;
			end else if (scl_rise && (st_ff == ST_ADDR || st_ff == ST_WR)) begin
				sh_reg_ff <= {sh_reg_ff[6:0], sda_ff};
				bit_ff <= bit_ff + 4'h1;
			end else if (scl_rise && st_ff == ST_RACK) begin
				nack_ff <= sda_ff;
			end else if (scl_fall) begin
				case (st_ff)
				ST_ADDR: if (bit_ff == 4'h8) begin
					if (sh_reg_ff[7:1] == `BLFS_SLAVE_ADDR) begin
						st_ff <= ST_AACK; sda_oe_ff <= 1'b1;
					end else st_ff <= ST_IDLE;
				end
				ST_AACK: begin
					bit_ff <= 4'h0;
					if (sh_reg_ff[0]) begin
						st_ff <= ST_RD;
						sh_reg_ff <= regs_ff[ptr_ff];
						sda_oe_ff <= ~regs_ff[ptr_ff][7];
					end else begin
						st_ff <= ST_WR; sda_oe_ff <= 1'b0;
					end
				end
				ST_WR: if (bit_ff == 4'h8) begin
					st_ff <= ST_WACK; sda_oe_ff <= 1'b1;
					if (!have_ptr_ff) begin
						have_ptr_ff <= 1'b1;
						ptr_ff <= (sh_reg_ff[2:0] == 3'h7) ? 3'h0 : sh_reg_ff[2:0];
					end else begin
						if (ptr_ff != `BLFS_REG_FAULT &&
							(ptr_ff != `BLFS_REG_MODE || strings_off))
							regs_ff[ptr_ff] <= sh_reg_ff;
						ptr_ff <= (ptr_ff == 3'h6) ? 3'h0 : ptr_ff + 3'h1;
					end
				end
				ST_WACK: begin
					st_ff <= ST_WR; bit_ff <= 4'h0; sda_oe_ff <= 1'b0;
				end
				ST_RD: begin
					bit_ff <= bit_ff + 4'h1;
					if (bit_ff == 4'h7) begin
						st_ff <= ST_RACK; sda_oe_ff <= 1'b0;
						ptr_ff <= (ptr_ff == 3'h6) ? 3'h0 : ptr_ff + 3'h1;
					end else begin
						sh_reg_ff <= {sh_reg_ff[6:0], 1'b0};
						sda_oe_ff <= ~sh_reg_ff[6];
					end
				end
				ST_RACK: if (nack_ff) begin
					st_ff <= ST_IDLE; // master done
				end else begin
					st_ff <= ST_RD; bit_ff <= 4'h0;
					sh_reg_ff <= regs_ff[ptr_ff]; sda_oe_ff <= ~regs_ff[ptr_ff][7];
				end
				default: st_ff <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

/* File: testbench/blfs_properties.sv */
/*
 checker for the fault outputs and bus busy flag of blfs_top.
 assumes it is bound to blfs_top and sees only its ports.
*/
`timescale 1ns/1ps
module blfs_properties #(
	parameter OV_QUAL_CYC = 50
) (
	input wire       clk,
	input wire       reset,
	input wire       scl_in,
	input wire       sda_in,
	input wire       over_voltage_guard,
	input wire [2:0] sink_short_high,
	input wire       switch_overcurrent_guard,
	input wire       temp_above_upper,
	input wire [2:0] string_sink_pin_unused,
	input wire       boost_enable_ff,
	input wire       switch_gate_ff,
	input wire [2:0] sink_enable_ff,
	input wire       standby_ff,
	input wire [7:0] fault_flags_ff,
	input wire       bus_busy_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	int   ov_cnt_ff; // raw cycles of over-voltage in a row
	logic rst_q_ff;  // masks the cycle after reset, flags legally drop then
	// over-voltage run length
	always @(posedge clk) begin
		ov_cnt_ff <= over_voltage_guard ? ov_cnt_ff + 1 : 0;
		rst_q_ff  <= reset;
	end
	sequence s_start;
		scl_in && $past(scl_in) && $fell(sda_in);
	endsequence
	sequence s_short;
		(|sink_short_high)[*6];
	endsequence
	property p_ov_qual;
		$rose(fault_flags_ff[0]) |-> ov_cnt_ff >= OV_QUAL_CYC;
	endproperty
	a_ov_qual: assert property (p_ov_qual) else $error("over-voltage flag too early");
	property p_open_ov;
		$rose(fault_flags_ff[4]) |-> fault_flags_ff[0];
	endproperty
	a_open_ov: assert property (p_open_ov) else $error("open flag without ov flag");
	property p_open_boost;
		$rose(fault_flags_ff[4]) |-> ##[0:2] !boost_enable_ff;
	endproperty
	a_open_boost: assert property (p_open_boost) else $error("boost on after open");
	property p_short;
		s_short |-> standby_ff && !boost_enable_ff && sink_enable_ff == 3'h0;
	endproperty
	a_short: assert property (p_short) else $error("short not stopped");
	property p_ocp;
		switch_overcurrent_guard[*6] |-> !switch_gate_ff;
	endproperty
	a_ocp: assert property (p_ocp) else $error("switch on in overcurrent");
	property p_ot;
		temp_above_upper[*7] |-> fault_flags_ff[2] && !boost_enable_ff;
	endproperty
	a_ot: assert property (p_ot) else $error("no thermal stop");
	property p_sticky;
		!rst_q_ff |-> ($past(fault_flags_ff) & ~fault_flags_ff) == 8'h00;
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault flag cleared");
	property p_unused;
		$stable(string_sink_pin_unused)[*6] |-> (sink_enable_ff & string_sink_pin_unused) == 3'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused sink enabled");
	property p_busy;
		s_start |-> ##[1:8] bus_busy_ff;
	endproperty
	a_busy: assert property (p_busy) else $error("bus not busy after start");
endmodule
bind blfs_top blfs_properties #(.OV_QUAL_CYC(OV_QUAL_CYC)) u_props (.clk(clk), .reset(reset),
	.scl_in(scl_in), .sda_in(sda_in), .over_voltage_guard(over_voltage_guard),
	.sink_short_high(sink_short_high), .switch_overcurrent_guard(switch_overcurrent_guard),
	.temp_above_upper(temp_above_upper), .string_sink_pin_unused(string_sink_pin_unused),
	.boost_enable_ff(boost_enable_ff), .switch_gate_ff(switch_gate_ff),
	.sink_enable_ff(sink_enable_ff), .standby_ff(standby_ff),
	.fault_flags_ff(fault_flags_ff), .bus_busy_ff(bus_busy_ff));

/* File: testbench/blfs_master.sv */
/*
 two-wire bus master model pulling open-drain lines low.
 assumes the bench resolves the wired levels with pull-ups.
*/
`timescale 1ns/1ps
module blfs_master (
	input  wire  scl,
	input  wire  sda,
	output logic scl_oe,
	output logic sda_oe
);
	localparam int Q = 20; // quarter of the 80 ns bus clock
	initial begin
		scl_oe = 0;
		sda_oe = 0;
	end
	// one bit slot, waits out a stretched clock for a bounded time
	task automatic bit_slot(input logic b, output logic r);
		int n;
		sda_oe = !b;
		#Q scl_oe = 0;
		n = 0;
		while (!scl && n < 400) begin
			#1 n++;
		end
		// a clock held low past the bound counts against the run
		if (n >= 400) begin
			blfs_top_bench.error_cnt++;
			$display("MISMATCH t=%0t clock held low too long", $time);
		end
		#Q r = sda;
		#Q scl_oe = 1;
		#Q;
	endtask
	// also serves as repeated start from a low clock
	task automatic start();
		#Q sda_oe = 0;
		#Q scl_oe = 0;
		#(2*Q) sda_oe = 1;
		#(2*Q) scl_oe = 1;
		#Q;
	endtask
	task automatic stop();
		sda_oe = 1;
		#(2*Q) scl_oe = 0;
		#(2*Q) sda_oe = 0;
		#(2*Q);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
		bit_slot(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, r);
			d[i] = r;
		end
		bit_slot(nack, r);
	endtask
endmodule

/* File: testbench/blfs_top_bench.sv */
/*
 self-checking bench for blfs_top driven by a bus master model.
 assumes shortened qualification and window counts.
*/
`timescale 1ns/1ps
module blfs_top_bench;
	logic       clk = 0;
	logic       reset = 1;
	logic [2:0] sink_headroom_low = 0;
	logic       over_voltage_guard = 0;
	logic [2:0] sink_short_high = 0;
	logic       switch_overcurrent_guard = 0;
	logic       switch_period_start = 0;
	logic       temp_above_upper = 0;
	logic       temp_below_restart = 0;
	wire        scl_oe_ff, sda_oe_ff, m_scl_oe, m_sda_oe, boost_enable_ff;
	wire        switch_gate_ff, standby_ff, bus_busy_ff;
	wire  [2:0] sink_enable_ff;
	wire  [7:0] fault_flags_ff;
	wire        scl = !(scl_oe_ff | m_scl_oe); // wired-and with pull-up
	wire        sda = !(sda_oe_ff | m_sda_oe);
	int         error_cnt = 0;
	int         n_tests = 0;
	always #2.5 clk = ~clk;
	// string 2 strapped unused, stretching never requested
	blfs_top #(.OV_QUAL_CYC(50), .OC_WIN_CYC(20)) DUT (.clk(clk), .reset(reset),
		.scl_in(scl), .scl_oe_ff(scl_oe_ff), .scl_out(), .sda_in(sda), .sda_oe_ff(sda_oe_ff),
		.sda_out(), .stretch_req(1'b0), .sink_headroom_low(sink_headroom_low),
		.over_voltage_guard(over_voltage_guard), .sink_short_high(sink_short_high),
		.switch_overcurrent_guard(switch_overcurrent_guard),
		.switch_period_start(switch_period_start), .temp_above_upper(temp_above_upper),
		.temp_below_restart(temp_below_restart), .string_sink_pin_unused(3'h4),
		.hardware_enable_pin(1'b1), .boost_enable_ff(boost_enable_ff),
		.switch_gate_ff(switch_gate_ff), .sink_enable_ff(sink_enable_ff),
		.standby_ff(standby_ff), .fault_flags_ff(fault_flags_ff), .bus_busy_ff(bus_busy_ff));
	blfs_master m (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		logic a;
		m.start();
		m.wbyte(8'h6C, a);
		m.wbyte(idx, a);
		m.wbyte(d, a);
		chk(8'(a), 8'h01, "write ack");
		m.stop();
	endtask
	task rd(input logic [7:0] idx, output logic [7:0] d);
		logic a;
		m.start();
		m.wbyte(8'h6C, a);
		m.wbyte(idx, a);
		m.start();
		m.wbyte(8'h6D, a);
		chk(8'(a), 8'h01, "read ack");
		m.rbyte(1'b1, d);
		m.stop();
	endtask
	task t_bus;
		logic [7:0] d;
		logic       a;
		wr(8'h00, 8'h01);
		wr(8'h01, 8'h60);
		rd(8'h01, d);
		chk(d, 8'h60, "mode written while strings off");
		wr(8'h00, 8'h0F);
		wr(8'h01, 8'h20);
		rd(8'h01, d);
		chk(d, 8'h60, "mode held while strings on");
		rd(8'h00, d);
		chk(d, 8'h0F, "reg0 readback");
		rd(8'h06, d);
		chk(d, 8'h00, "fault reg after reset");
		chk(8'(sink_enable_ff[2]), 8'h00, "unused sink");
		m.start();
		m.wbyte(8'h6E, a);
		chk(8'(a), 8'h00, "foreign address");
		chk(8'(bus_busy_ff), 8'h01, "busy in frame");
		m.stop();
		step(8);
		chk(8'(bus_busy_ff), 8'h00, "free after stop");
		$display("test bus done");
	endtask
	task t_oc;
		switch_period_start = 1;
		step(1);
		switch_period_start = 0;
		switch_overcurrent_guard = 1;
		step(6);
		chk(8'(switch_gate_ff), 8'h00, "gate off");
		for (int i = 0; i < 80; i++) begin
			switch_overcurrent_guard = 1;
			step(3);
			switch_overcurrent_guard = 0;
			step(7);
			if (i == 49) chk(fault_flags_ff & 8'h02, 8'h00, "too few windows");
		end
		chk(fault_flags_ff & 8'h02, 8'h02, "overcurrent flag");
		$display("test overcurrent done");
	endtask
	task t_ov;
		logic [7:0] d;
		over_voltage_guard = 1;
		step(30);
		over_voltage_guard = 0;
		step(8);
		chk(fault_flags_ff & 8'h11, 8'h00, "short excursion");
		sink_headroom_low = 3'h1;
		over_voltage_guard = 1;
		step(70);
		chk(fault_flags_ff & 8'h11, 8'h11, "open string flags");
		chk(8'(boost_enable_ff), 8'h00, "boost off");
		over_voltage_guard = 0;
		sink_headroom_low = 3'h0;
		rd(8'h06, d);
		chk(d & 8'h13, 8'h13, "flags held and readable");
		$display("test overvoltage done");
	endtask
	task t_hot_short;
		temp_above_upper = 1;
		step(8);
		chk(fault_flags_ff & 8'h04, 8'h04, "temperature flag");
		chk(8'(boost_enable_ff), 8'h00, "stopped when hot");
		chk(8'(sink_enable_ff), 8'h00, "sinks off when hot");
		temp_above_upper = 0;
		temp_below_restart = 1;
		step(8);
		chk(8'(sink_enable_ff), 8'h03, "restart after cooling");
		sink_short_high = 3'h2;
		step(8);
		chk(8'(standby_ff), 8'h01, "standby on short");
		chk(8'(sink_enable_ff), 8'h00, "sinks off on short");
		$display("test shutdown done");
	endtask
	initial begin
		step(4);
		reset = 0;
		step(6);
		t_bus;
		t_oc;
		t_ov;
		t_hot_short;
		test_done;
	end
	// hang guard
	initial begin
		#400000;
		error_cnt++;
		$display("MISMATCH t=%0t timeout", $time);
		test_done;
	end
endmodule
